/* tb_usbhcr_top.sv */
// self-checking bench of the channel result and setup block
`timescale 1ns/100ps
module tb_usbhcr_top;
    logic clk, rst, cyc, stb, we, ack, irq;
    logic [13:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, d;
    logic [2:0] rcode;
    usbhcr_pkg::usbhcr_aend_t aend;
    usbhcr_pkg::usbhcr_chin_t [3:0] chin;
    usbhcr_pkg::usbhcr_chout_t [3:0] chout;
    int n_mismatch, check_count;
    logic [13:0] base[4] = '{14'h0680, 14'h06C0, 14'h0700, 14'h0740}; // setup b..e
    // end reports and the codes they must give; last entry leaves a nonzero code
    logic [12:0] ev[11] = '{13'h1001, 13'h1800, 13'h1400, 13'h1200, 13'h1180, 13'h1460, 13'h1102, 13'h1010,
                            13'h1008, 13'h1004, 13'h11C0};
    logic [2:0] ex[11] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
    usbhcr_top u_usbhcr_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .aend_i(aend),
        .chin_i(chin), .chout_o(chout), .result_code_o(rcode), .irq_o(irq));
    usbhcr_peer u_usbhcr_peer (.clk_i(clk), .aend_o(aend), .chin_o(chin));
    // ------------------------------------------------------------------
    // bus cycles and compares
    // ------------------------------------------------------------------
    // request held until ack is seen at a rising edge, then released
    task bus(input logic w, input logic [13:0] a, input logic [7:0] v);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, v};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        d = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t register read %h expected %h", $time, g, e);
        end
    endtask
    task chk_pin(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t port value %h expected %h", $time, g, e);
        end
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset values, read-only result, unmapped place
    task t_regs;
        bus(0, 14'h0678, 0); chk_reg(d, 0);
        for (int i = 0; i < 4; i++)
        begin
            bus(0, base[i], 0); chk_reg(d, 0);
        end
        bus(1, 14'h0678, 8'h70); bus(0, 14'h0678, 0); chk_reg(d, 0);
        bus(1, 14'h07FC, 8'hFF); bus(0, 14'h07FC, 0); chk_reg(d, 0);
        chk_pin(irq, 0);
    endtask
    // every outcome class, priorities, and a report without done
    task t_result;
        for (int i = 0; i < 11; i++)
        begin
            u_usbhcr_peer.send_end(ev[i]);
            @(posedge clk); chk_pin(rcode, ex[i]);
            bus(0, 14'h0678, 0); chk_reg(d, {25'h0, ex[i], 4'h0});
        end
        u_usbhcr_peer.send_end(13'h0800);
        @(posedge clk); chk_pin(rcode, 3'h4);
    endtask
    // masked event, enabled abort, clear
    task t_irq;
        bus(1, 14'h0784, 8'h3F); bus(1, 14'h0788, 8'h20);
        u_usbhcr_peer.send_end(13'h1000);
        bus(0, 14'h0780, 0); chk_reg(d, 32'h10); chk_pin(irq, 0);
        u_usbhcr_peer.send_end(13'h1001);
        bus(0, 14'h0780, 0); chk_reg(d, 32'h30); chk_pin(irq, 1);
        bus(1, 14'h0784, 8'h20); bus(0, 14'h0780, 0); chk_reg(d, 32'h10); chk_pin(irq, 0);
        bus(1, 14'h0788, 8'h00);
    endtask
    // setup of one channel: speed, toggle, go, ack target, stop or done
    task t_chan(input int i, input int cnt, input int spd);
        logic [7:0] v;
        v = {cnt[3:0], spd[1:0], 2'b10};
        bus(1, base[i], v); bus(0, base[i], 0); chk_reg(d, {24'h0, v});
        chk_pin(chout[i].peer_speed_select, spd[1:0]); chk_pin(chout[i].toggle, 1);
        bus(1, base[i], v | 8'h01);
        @(posedge clk); chk_pin({chout[i].go, chout[i].start}, 2'b11);
        @(posedge clk); chk_pin(chout[i].start, 0);
        bus(1, base[i], (v & 8'hFD) | 8'h01);
        @(posedge clk); chk_pin(chout[i].toggle, 1);
        u_usbhcr_peer.pulse(i, 4'h4, 0);
        @(posedge clk); chk_pin(chout[i].toggle, 0);
        repeat (((cnt == 0) ? 16 : cnt) - 1) u_usbhcr_peer.pulse(i, 4'h8, i);
        repeat (3) @(posedge clk);
        bus(0, 14'h0780, 0); chk_pin(d[i], 0);
        u_usbhcr_peer.pulse(i, 4'h8, 0);
        repeat (3) @(posedge clk);
        bus(0, 14'h0780, 0); chk_pin(d[i], 1);
        // channel b ends by engine done, which the go checks watch; e is stopped by software
        if (i == 3)
        begin
            bus(1, base[i], v);
            @(posedge clk); chk_pin({chout[i].go, chout[i].stop}, 2'b01);
        end
        else
        begin
            u_usbhcr_peer.pulse(i, 4'h1, 0);
            @(posedge clk); chk_pin(chout[i].go, 0);
        end
        bus(1, 14'h0784, 8'h0F);
    endtask
    // verdict and end of run
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize;
    end
    initial
    begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = 4'hF; wdat = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_result;
        t_irq;
        t_chan(0, 1, 0);
        t_chan(1, 3, 1);
        t_chan(2, 15, 3);
        t_chan(3, 0, 1);
        summarize;
    end
endmodule // tb_usbhcr_top

/* usbhcr_map.svh */
// register offsets, field positions and reset values of the host channel block
`ifndef USBHCR_MAP_SVH
`define USBHCR_MAP_SVH
// ----------------------------------------------------------------------------
// Notes on behaviour
// - channel a result field, read only, three bits
// - code 000 when transfer ended cleanly
// - code 001 when endpoint answered stall
// - code 010 on oversize packet or total exceeded
// - crc plus stuffing error counts as retry
// - short packet with toggle mismatch is retry
// - code 011 when short packet ends below total
// - code 100 on timeout, crc, stuffing, pid, toggle
// - raise ack target flag after programmed ack count
// - two-bit speed per channel, 10 never programmed
// - toggle bit loads at start, tracks live state
// - go bit starts, stays high, clearing stops channel
// - mass storage halt records cause, 000 bad wrapper
// ----------------------------------------------------------------------------
// register indices; byte address is four times the index
`define USBHCR_IDX_RESULT 12'h19E
`define USBHCR_IDX_SETUP_B 12'h1A0
`define USBHCR_IDX_SETUP_C 12'h1B0
`define USBHCR_IDX_SETUP_D 12'h1C0
`define USBHCR_IDX_SETUP_E 12'h1D0
`define USBHCR_IDX_IRQ_STAT 12'h1E0
`define USBHCR_IDX_IRQ_CLR 12'h1E1
`define USBHCR_IDX_IRQ_EN 12'h1E2
// field positions
`define USBHCR_RES_LSB 4
`define USBHCR_ACK_LSB 4
`define USBHCR_SPD_LSB 2
`define USBHCR_TOG_BIT 1
`define USBHCR_GO_BIT 0
// interrupt status bits: [3:0] ack target b..e, [4] channel a end, [5] abort
`define USBHCR_IRQ_DONE_BIT 4
`define USBHCR_IRQ_ABORT_BIT 5
`define USBHCR_IRQ_W 6
// reset values
`define USBHCR_RST_RESULT 8'h00
`define USBHCR_RST_SETUP 8'h00
`define USBHCR_RST_IRQ 6'h00
// ack target of sixteen, used when the ack field is zero
`define USBHCR_ACK_SIXTEEN 5'h10
`endif

/* usbhcr_peer.sv */
// stand-in for the link engine and attached peripheral feeding the block
`timescale 1ns/100ps
module usbhcr_peer (
    input wire logic clk_i,
    output usbhcr_pkg::usbhcr_aend_t aend_o,
    output usbhcr_pkg::usbhcr_chin_t [3:0] chin_o
);
    // idle: no strobes
    initial
    begin
        aend_o = '0;
        chin_o = '0;
    end
    task send_end(input logic [12:0] v);
        @(posedge clk_i);
        aend_o <= v;
        @(posedge clk_i);
        aend_o <= '0;
    endtask
    // one-cycle channel strobe, then gap idle cycles so slow peers are seen too
    task pulse(input int ch, input logic [3:0] v, input int gap);
        @(posedge clk_i);
        chin_o[ch] <= v;
        @(posedge clk_i);
        chin_o[ch] <= 4'h0;
        repeat (gap) @(posedge clk_i);
    endtask
endmodule // usbhcr_peer

/* usbhcr_pkg.sv */
// types shared by the host channel result and setup block
package usbhcr_pkg;
    // result codes of channel a
    typedef enum logic [2:0] {
        RESULT_CLEAN = 3'h0,
        RESULT_STALL = 3'h1,
        RESULT_TOO_MUCH_DATA = 3'h2,
        RESULT_SHORT_DATA = 3'h3,
        RESULT_LINK_FAULT = 3'h4
    } usbhcr_result_t;
    // end-of-transfer report of channel a from the link engine
    typedef struct packed {
        logic done;        // one-cycle pulse: transfer ended
        logic stall;       // stall handshake seen
        logic oversize;    // packet longer than max packet size
        logic over_total;  // received bytes beyond transfer_byte_total
        logic short_pkt;   // packet shorter than max packet size
        logic below_total; // received bytes still under the total
        logic crc_err;
        logic stuff_err;
        logic timeout;     // no data or no handshake in time
        logic pid_check;   // pid check bits failed
        logic pid_undef;   // undefined pid
        logic tog_miss;    // toggle mismatch
        logic ms_abort;    // mass storage sequence halted
    } usbhcr_aend_t;
    // per-channel report from the link engine, channels b..e
    typedef struct packed {
        logic ack_seen; // pulse per ack handshake
        logic tog_upd;  // pulse: new toggle state
        logic tog_val;
        logic done;     // pulse: channel finished, go drops
    } usbhcr_chin_t;
    // per-channel control towards the link engine
    typedef struct packed {
        logic go;
        logic start;    // pulse when go rises
        logic stop;     // pulse when software clears go
        logic [1:0] peer_speed_select;
        logic toggle;
    } usbhcr_chout_t;
endpackage

/* usbhcr_props.sv */
// concurrent checks on the port behaviour of the host channel block
`timescale 1ns/100ps
module usbhcr_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire usbhcr_pkg::usbhcr_aend_t aend_i,
    input wire usbhcr_pkg::usbhcr_chin_t [3:0] chin_i,
    input wire usbhcr_pkg::usbhcr_chout_t [3:0] chout_o,
    input wire logic [2:0] result_code_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------------
    // expected result code
    // ------------------------------------------------------------------
    logic [2:0] exp_code; // code that the current end report must yield
    // link faults outrank stall, stall outranks overrun and underrun
    always_comb
    begin
        if (aend_i.timeout | aend_i.crc_err | aend_i.stuff_err | aend_i.pid_check | aend_i.pid_undef | aend_i.tog_miss)
            exp_code = 3'h4;
        else if (aend_i.stall)
            exp_code = 3'h1;
        else if (aend_i.oversize | aend_i.over_total)
            exp_code = 3'h2;
        else if (aend_i.short_pkt & aend_i.below_total)
            exp_code = 3'h3;
        else
            exp_code = 3'h0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus request not answered next cycle");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_code_fault; aend_i.done && exp_code == 3'h4 |=> result_code_o == 3'h4; endproperty
    a_code_fault: assert property (p_code_fault) else $error("retry code missing");
    property p_code_stall; aend_i.done && exp_code == 3'h1 |=> result_code_o == 3'h1; endproperty
    a_code_stall: assert property (p_code_stall) else $error("stall code missing");
    property p_code_over; aend_i.done && exp_code == 3'h2 |=> result_code_o == 3'h2; endproperty
    a_code_over: assert property (p_code_over) else $error("overrun code missing");
    property p_code_short; aend_i.done && exp_code == 3'h3 |=> result_code_o == 3'h3; endproperty
    a_code_short: assert property (p_code_short) else $error("underrun code missing");
    property p_code_clean; aend_i.done && exp_code == 3'h0 |=> result_code_o == 3'h0; endproperty
    a_code_clean: assert property (p_code_clean) else $error("clean code missing");
    property p_code_hold; !aend_i.done |=> $stable(result_code_o); endproperty
    a_code_hold: assert property (p_code_hold) else $error("result moved without transfer end");
    property p_go_start; $rose(chout_o[0].go) |-> chout_o[0].start; endproperty
    a_go_start: assert property (p_go_start) else $error("go rose without start pulse");
    property p_go_done; chout_o[0].go && chin_i[0].done && !wb_cyc_i |=> !chout_o[0].go; endproperty
    a_go_done: assert property (p_go_done) else $error("go stayed after channel done");
    // main scenarios reached
    c_abort: cover property (aend_i.done && aend_i.ms_abort);
    c_start: cover property (chout_o[0].start);
    c_irq: cover property (irq_o);
endmodule // usbhcr_props

bind usbhcr_top usbhcr_props u_usbhcr_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .aend_i(aend_i), .chin_i(chin_i), .chout_o(chout_o), .result_code_o(result_code_o),
    .irq_o(irq_o));

/* usbhcr_top.sv */
// result code register of channel a and setup registers of channels b..e
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`include "usbhcr_map.svh"

module usbhcr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link engine, same clock
    input wire usbhcr_pkg::usbhcr_aend_t aend_i,
    input wire usbhcr_pkg::usbhcr_chin_t [3:0] chin_i,
    output usbhcr_pkg::usbhcr_chout_t [3:0] chout_o,
    output logic [2:0] result_code_o,
    output logic irq_o
);

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------

    // the slave answers every request after exactly one cycle, whatever the address
    logic ack_q;           // registered answer
    logic ack_d;
    logic [31:0] rdat_q;   // read data captured in request cycle
    logic [31:0] rdat_d;
    logic req;             // request seen, not yet answered
    logic commit;          // edge at which a write takes effect
    logic [11:0] idx;      // word index
    logic wr;              // write that commits now on lane 0

    // a new request is one not yet answered; while ack stands the master
    // still holds the same request, so it must not be taken twice
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    // writes land at the edge where the master sees ack, never earlier, so a
    // request withdrawn before its answer leaves no trace in the registers
    assign commit = wb_cyc_i & wb_stb_i & ack_q;
    // registers sit on word boundaries; the two low address bits are ignored
    assign idx = wb_adr_i[13:2];
    // all registers live in byte lane 0, so only its enable gates a write
    assign wr = commit & wb_we_i & wb_sel_i[0];

    // ------------------------------------------------------------------------
    // channel a result
    // ------------------------------------------------------------------------

    logic [2:0] res_q;     // result_code of channel a
    logic [2:0] res_d;
    logic fault;           // any link fault condition

    // retry-class causes dominate every size class
    // a damaged packet cannot be trusted to tell its own length, so size
    // judgements are only made on packets that arrived intact
    always_comb
    begin
        fault = aend_i.timeout | aend_i.crc_err | aend_i.stuff_err
            | aend_i.pid_check | aend_i.pid_undef;
        fault = fault | aend_i.tog_miss;
        fault = fault | (aend_i.crc_err & aend_i.stuff_err);
        res_d = res_q;
        if (aend_i.done)
        begin
            if (fault)
            begin
                res_d = usbhcr_pkg::RESULT_LINK_FAULT;
            end
            else if (aend_i.stall)
            begin
                res_d = usbhcr_pkg::RESULT_STALL;
            end
            else if (aend_i.oversize | aend_i.over_total)
            begin
                res_d = usbhcr_pkg::RESULT_TOO_MUCH_DATA;
            end
            else if (aend_i.short_pkt & aend_i.below_total)
            begin
                res_d = usbhcr_pkg::RESULT_SHORT_DATA;
            end
            // a mass storage halt with a clean code means a bad status wrapper
            // clean end, bad wrapper
            else
            begin
                res_d = usbhcr_pkg::RESULT_CLEAN;
            end
        end
    end

    // result register, updated only by end reports
    // synchronous reset; the field reads 000 until the first transfer ends
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            res_q <= 3'h0;
        end
        else
        begin
            res_q <= res_d;
        end
    end

    assign result_code_o = res_q;

    // ------------------------------------------------------------------------
    // channels b..e
    // ------------------------------------------------------------------------

    logic [3:0][7:0] setup_q;  // chan_b..e_setup_zero
    logic [3:0] ack_hit;       // ack_target_reached events

    // one copy of the setup logic per channel; channel b is index 0 and the
    // register index of each next channel lies sixteen words further on
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_chan
            logic [7:0] set_q;
            logic [7:0] set_d;
            logic [4:0] cnt_q;     // acks counted so far
            logic [4:0] cnt_d;
            logic start_q;         // start pulse to engine
            logic start_d;
            logic stop_q;          // stop pulse to engine
            logic stop_d;
            logic hit_q;           // target reached pulse
            logic hit_d;
            logic [4:0] target;
            logic sel;

            assign sel = wr & (idx == (`USBHCR_IDX_SETUP_B + 12'(g * 16)));

            // the target is one bit wider than the field to hold the value sixteen
            // zero means sixteen
            assign target = (set_q[7:4] == 4'h0) ? `USBHCR_ACK_SIXTEEN : {1'b0, set_q[7:4]};

            // settings, go and toggle tracking, ack counting
            always_comb
            begin
                set_d = set_q;
                cnt_d = cnt_q;
                start_d = 1'b0;
                stop_d = 1'b0;
                hit_d = 1'b0;
                // software raising go from idle in the same cycle is handled below and wins; writing go=1 while go is high does not keep it
                // engine end drops go
                if (chin_i[g].done)
                begin
                    set_d[`USBHCR_GO_BIT] = 1'b0;
                end
                if (chin_i[g].tog_upd & set_q[`USBHCR_GO_BIT])
                begin
                    set_d[`USBHCR_TOG_BIT] = chin_i[g].tog_val;
                end
                // the counter restarts at the target, so a long transfer raises
                // the flag once per programmed number of acks
                // count acks to target
                if (chin_i[g].ack_seen & set_q[`USBHCR_GO_BIT])
                begin
                    if (cnt_q + 5'h01 >= target)
                    begin
                        cnt_d = 5'h00;
                        hit_d = 1'b1;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                // software writes come last, but with go high they leave toggle and count to the engine; only a go raised from idle overrides a done
                if (sel)
                begin
                    set_d[7:2] = wb_dat_i[7:2];
                    if (wb_dat_i[`USBHCR_GO_BIT] & ~set_q[`USBHCR_GO_BIT])
                    begin
                        set_d[`USBHCR_TOG_BIT] = wb_dat_i[`USBHCR_TOG_BIT];
                        set_d[`USBHCR_GO_BIT] = 1'b1;
                        start_d = 1'b1;
                        cnt_d = 5'h00;
                    end
                    else if (~wb_dat_i[`USBHCR_GO_BIT] & set_q[`USBHCR_GO_BIT])
                    begin
                        // fifo and remaining size live in the engine and stay put
                        set_d[`USBHCR_GO_BIT] = 1'b0;
                        stop_d = 1'b1;
                    end
                    else if (~set_q[`USBHCR_GO_BIT])
                    begin
                        // idle channel: toggle may be preset freely
                        set_d[`USBHCR_TOG_BIT] = wb_dat_i[`USBHCR_TOG_BIT];
                    end
                end
            end

            // channel state registers
            // start, stop and hit are registered so the engine and the interrupt status see clean one-cycle pulses
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    set_q <= `USBHCR_RST_SETUP;
                    cnt_q <= 5'h00;
                    start_q <= 1'b0;
                    stop_q <= 1'b0;
                    hit_q <= 1'b0;
                end
                else
                begin
                    set_q <= set_d;
                    cnt_q <= cnt_d;
                    start_q <= start_d;
                    stop_q <= stop_d;
                    hit_q <= hit_d;
                end
            end

            // outputs towards the link engine come straight from flip-flops
            assign setup_q[g] = set_q;
            assign ack_hit[g] = hit_q;
            assign chout_o[g].go = set_q[`USBHCR_GO_BIT];
            assign chout_o[g].start = start_q;
            assign chout_o[g].stop = stop_q;
            assign chout_o[g].peer_speed_select = set_q[3:2];
            assign chout_o[g].toggle = set_q[`USBHCR_TOG_BIT];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------------------

    logic [5:0] ist_q;   // sticky status
    logic [5:0] ist_d;
    logic [5:0] ien_q;   // enable mask
    logic [5:0] ien_d;
    logic [5:0] ev;      // events this cycle

    // new events win over a clear in the same cycle
    // a clear and an event of one cycle leave the bit set, so no event is lost
    always_comb
    begin
        ev = {aend_i.done & aend_i.ms_abort, aend_i.done, ack_hit};
        ist_d = ist_q;
        ien_d = ien_q;
        if (wr & (idx == `USBHCR_IDX_IRQ_CLR))
        begin
            ist_d = ist_d & ~wb_dat_i[5:0];
        end
        ist_d = ist_d | ev;
        if (wr & (idx == `USBHCR_IDX_IRQ_EN))
        begin
            ien_d = wb_dat_i[5:0];
        end
    end

    // interrupt registers
    // status and enable both start empty, so irq_o is low out of reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ist_q <= `USBHCR_RST_IRQ;
            ien_q <= `USBHCR_RST_IRQ;
        end
        else
        begin
            ist_q <= ist_d;
            ien_q <= ien_d;
        end
    end

    // level interrupt: high while any enabled status bit is set
    assign irq_o = |(ist_q & ien_q);

    // ------------------------------------------------------------------------
    // read mux and answer
    // ------------------------------------------------------------------------

    // read data captured when the request arrives; unmapped reads give zero
    // the clear register reads as zero: it acts on writes only
    always_comb
    begin
        ack_d = req;
        rdat_d = rdat_q;
        if (req)
        begin
            rdat_d = 32'h0000_0000;
            unique case (idx)
                `USBHCR_IDX_RESULT: rdat_d[6:4] = res_q;
                `USBHCR_IDX_SETUP_B: rdat_d[7:0] = setup_q[0];
                `USBHCR_IDX_SETUP_C: rdat_d[7:0] = setup_q[1];
                `USBHCR_IDX_SETUP_D: rdat_d[7:0] = setup_q[2];
                `USBHCR_IDX_SETUP_E: rdat_d[7:0] = setup_q[3];
                `USBHCR_IDX_IRQ_STAT: rdat_d[5:0] = ist_q;
                `USBHCR_IDX_IRQ_EN: rdat_d[5:0] = ien_q;
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // bus answer registers
    // the answer always follows one cycle after the request; the master must
    // drop its request after ack before it may start the next one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ack and read data both come from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule // usbhcr_top
